// ==== asrd_pkg.sv ====
// Constants, field layouts and carrier types of the serial register decoder
package asrd_pkg;
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam int POS_WRITE = 15;
    localparam int POS_TGT_HI = 14;
    localparam int POS_TGT_LO = 13;
    localparam int POS_DATA_HI = 12;
    localparam int POS_CTRL_LO = 1;
    localparam int POS_BYTE_LO = 5;

    // Register widths and reset values
    localparam int CTRL_W = 12;
    localparam int RANGE_W = 8;
    localparam int SEQ_W = 8;
    localparam int CHAN_N = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
    localparam logic [RANGE_W-1:0] RANGE_RESET = 8'h00;
    localparam logic [SEQ_W-1:0] SEQ_RESET = 8'h00;

    // Register targets in the frame header
    localparam logic [1:0] TGT_CTRL = 2'h0;
    localparam logic [1:0] TGT_RANGE_LO = 2'h1;
    localparam logic [1:0] TGT_RANGE_HI = 2'h2;
    localparam logic [1:0] TGT_SEQ = 2'h3;

    // Input configuration codes
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_PSEUDO_PAIR = 2'h1;
    localparam logic [1:0] CFG_DIFF_PAIR = 2'h2;
    localparam logic [1:0] CFG_PSEUDO_7 = 2'h3;
    localparam logic [2:0] CHAN_COMMON_NEG = 3'h7;

    // Power mode codes
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_AUTO_STBY = 2'h1;
    localparam logic [1:0] PWR_AUTO_SHDN = 2'h2;
    localparam logic [1:0] PWR_FULL_SHDN = 2'h3;

    // Sequencer codes
    localparam logic [1:0] SEQ_OFF_A = 2'h0;
    localparam logic [1:0] SEQ_FLAGGED = 2'h1;
    localparam logic [1:0] SEQ_CONSEC = 2'h2;
    localparam logic [1:0] SEQ_OFF_B = 2'h3;

    // Range codes
    localparam logic [1:0] RANGE_PM10 = 2'h0;
    localparam logic [1:0] RANGE_PM5 = 2'h1;
    localparam logic [1:0] RANGE_PM2P5 = 2'h2;
    localparam logic [1:0] RANGE_UNI10 = 2'h3;

    // Control register image, most significant field first
    typedef struct packed {
        logic [2:0] chan_addr;     // chan_addr_msb..chan_addr_lsb
        logic [1:0] input_cfg;     // input_cfg_hi, input_cfg_lo
        logic [1:0] power_sel;     // power_sel_hi, power_sel_lo
        logic coding_binary;
        logic ref_internal;
        logic [1:0] sequencer_ctrl; // sequencer_ctrl_hi, sequencer_ctrl_lo
        logic dout_weak;
    } asrd_ctrl_s;

    // Settings handed to the conversion datapath
    typedef struct packed {
        logic [2:0] pos_input;
        logic [2:0] neg_input;
        logic neg_is_ground;
        logic [1:0] range_code;
        logic coding_binary;
        logic ref_internal;
    } asrd_conv_s;

    typedef enum logic [2:0] {
        PWR_ST_ON = 3'h1,
        PWR_ST_STBY = 3'h2,
        PWR_ST_OFF = 3'h4
    } asrd_pwr_e;
endpackage

// ==== asrd_top.sv ====
// Serial write-frame decoder and configuration registers of the converter
`timescale 1ns/1ps

// Overview of operation
// - A frame is 16 serial clocks; first three bits are write flag and target.
// - Write flag zero: whole frame ignored, no register changes.
// - Header 1,00 loads the next 12 bits into the control register.
// - Header 1,01 loads 8 bits into range register for channels 0-3.
// - Header 1,10 loads 8 bits into range register for channels 4-7.
// - Header 1,11 loads 8 bits into the sequence selection register.
// - All four registers are write-only; no read-back path exists.
// - Power-up clears all twelve control register bits.
// - Input, coding and reference settings written in a frame apply from the next conversion onward; power mode acts at once.
// - Bits 12-10 address the channel, or the last channel of a consecutive sequence.
// - Bits 9-8 pick single-ended, pseudo pairs, differential pairs or seven pseudo.
// - Input pairing per configuration; address 7 forbidden in seven-pseudo mode.
// - Bits 7-6 select one of four power modes.
// - Bit 5 selects two's complement (0) or straight binary (1).
// - Sequencing applies the latest coding setting to every channel.
// - Bit 4 selects external (0) or internal (1) reference.
// - Sequencing applies the latest reference setting to every channel.
// - Bits 3-2 control whether and how the sequencer runs.
// - Bit 1: weakly drive data-out with next channel msb, else three-state.
// - Power codes: always on, standby after conversion, shutdown after, shutdown now.
// - Sequencer: 00/11 off, 01 ascending flagged channels, 10 zero to address.
// - Range codes: +-10V, +-5V, +-2.5V, 0-10V; every channel defaults to 00.
module asrd_top
    import asrd_pkg::*;
(
    input wire logic clk_sys,                 // System clock, 40 MHz
    input wire logic rst_n,                   // Reset, active low; synchronous except frame_done_reg
    input wire logic sclk_link,               // Serial clock from host
    input wire logic cs_n,                    // Chip select from host, active low
    input wire logic din,                     // Serial data in, link domain
    input wire logic conv_start,              // Datapath pulse: conversion begins
    input wire logic conv_done,               // Datapath pulse: conversion ends
    output logic dout_o,                      // Data-out idle level
    output logic dout_oe,                     // Data-out enable, high while driving
    output logic dout_weak_drv,               // Data-out drive is weak
    output asrd_ctrl_s ctrl_q,                // Control register contents
    output logic [RANGE_W-1:0] range_lo_q,    // Ranges of channels 0-3
    output logic [RANGE_W-1:0] range_hi_q,    // Ranges of channels 4-7
    output logic [SEQ_W-1:0] seq_sel_q,       // Sequence selection, bit 7 is channel 0
    output asrd_conv_s conv_cfg,              // Settings of the running conversion
    output logic addr_illegal,                // Address 7 in seven-input mode
    output logic pwr_analog_on,               // Analog core powered
    output logic pwr_ref_on                   // Internal reference powered
);

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [1:0] range_of(input logic [2:0] ch, input logic [RANGE_W-1:0] lo,
                                            input logic [RANGE_W-1:0] hi);
        logic [RANGE_W-1:0] r;
        logic [2:0] sh;
        r = ch[2] ? hi : lo;
        sh = {~ch[1:0], 1'b0};
        range_of = r[sh +: 2];
    endfunction

    // Next flagged channel strictly above cur, wrapping; cur if none flagged
    function automatic logic [2:0] next_flagged(input logic [2:0] cur, input logic [SEQ_W-1:0] sel);
        logic [2:0] cand;
        logic found;
        next_flagged = cur;
        found = 1'b0;
        for (int i = 1; i <= CHAN_N; i++) begin
            cand = 3'(cur + 3'(i));
            if (!found && sel[3'(CHAN_N - 1) - cand]) begin
                next_flagged = cand;
                found = 1'b1;
            end
        end
    endfunction

    // ************************************************************
    // Link domain: shift in the frame
    // ************************************************************
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [CNT_W-1:0] bit_cnt_next;
    logic [FRAME_BITS-2:0] shift_reg;
    logic [FRAME_BITS-1:0] frame_word_reg;
    logic frame_done_reg;
    wire frame_last = (bit_cnt_reg == CNT_LAST);

    // Saturates after the last bit so extra clocks never re-capture
    assign bit_cnt_next = (bit_cnt_reg > CNT_LAST) ? bit_cnt_reg : 5'(bit_cnt_reg + 5'h01);

    always_ff @(posedge sclk_link or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_reg <= CNT_ZERO;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    always_ff @(posedge sclk_link) begin
        shift_reg <= {shift_reg[FRAME_BITS-3:0], din};
    end

    always_ff @(posedge sclk_link) begin
        if (frame_last) begin
            frame_word_reg <= {shift_reg, din};
        end
    end

    // Level stays up until the first bit of the next frame
    always_ff @(posedge sclk_link or negedge rst_n) begin
        if (!rst_n) begin
            frame_done_reg <= 1'b0;
        end else if (frame_last) begin
            frame_done_reg <= 1'b1;
        end else if (bit_cnt_reg == CNT_ZERO) begin
            frame_done_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Crossing into the system domain
    // ************************************************************
    logic done_s1_reg;
    logic done_s2_reg;
    logic done_s3_reg;
    logic cs_s1_reg;
    logic cs_s2_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_s3_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
        end else begin
            done_s1_reg <= frame_done_reg;
            done_s2_reg <= done_s1_reg;
            done_s3_reg <= done_s2_reg;
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
        end
    end

    // Frame word is stable for many cycles once the synced level rises
    wire frame_commit = done_s2_reg & ~done_s3_reg;
    wire wr_flag = frame_word_reg[POS_WRITE];
    wire [1:0] wr_tgt = frame_word_reg[POS_TGT_HI:POS_TGT_LO];
    // Bit 0 is not part of the image
    wire [CTRL_W-1:0] wr_ctrl = frame_word_reg[POS_DATA_HI:POS_CTRL_LO];
    wire [RANGE_W-1:0] wr_byte = frame_word_reg[POS_DATA_HI:POS_BYTE_LO];
    wire wr_go = frame_commit & wr_flag;
    wire ld_ctrl = wr_go & (wr_tgt == TGT_CTRL);
    wire ld_rlo = wr_go & (wr_tgt == TGT_RANGE_LO);
    wire ld_rhi = wr_go & (wr_tgt == TGT_RANGE_HI);
    wire ld_seq = wr_go & (wr_tgt == TGT_SEQ);

    // ************************************************************
    // Configuration registers (write-only from the link)
    // ************************************************************
    asrd_ctrl_s ctrl_reg;
    logic [RANGE_W-1:0] range_lo_reg;
    logic [RANGE_W-1:0] range_hi_reg;
    logic [SEQ_W-1:0] seq_sel_reg;

    // Cleared at reset; nothing reads back to the link
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_reg <= asrd_ctrl_s'(CTRL_RESET);
            range_lo_reg <= RANGE_RESET;
            range_hi_reg <= RANGE_RESET;
            seq_sel_reg <= SEQ_RESET;
        end else begin
            if (ld_ctrl) ctrl_reg <= asrd_ctrl_s'(wr_ctrl);
            if (ld_rlo) range_lo_reg <= wr_byte;
            if (ld_rhi) range_hi_reg <= wr_byte;
            if (ld_seq) seq_sel_reg <= wr_byte;
        end
    end

    assign ctrl_q = ctrl_reg;
    assign range_lo_q = range_lo_reg;
    assign range_hi_q = range_hi_reg;
    assign seq_sel_q = seq_sel_reg;

    // ************************************************************
    // Channel selection and sequencing
    // ************************************************************
    logic [2:0] chan_reg;
    logic [2:0] chan_next;
    logic seq_run_reg;

    wire seq_flagged = (ctrl_reg.sequencer_ctrl == SEQ_FLAGGED);
    wire seq_consec = (ctrl_reg.sequencer_ctrl == SEQ_CONSEC);
    wire seq_on = seq_flagged | seq_consec;
    // Lowest flagged channel starts a flagged sequence
    wire [2:0] first_flagged = next_flagged(CHAN_COMMON_NEG, seq_sel_reg);
    wire [2:0] step_flagged = next_flagged(chan_reg, seq_sel_reg);
    // Consecutive run ends at the addressed channel
    wire [2:0] step_consec = (chan_reg >= ctrl_reg.chan_addr) ? 3'h0 : 3'(chan_reg + 3'h1);
    wire [2:0] start_chan = seq_flagged ? first_flagged : seq_consec ? 3'h0 : ctrl_reg.chan_addr;

    assign chan_next = !seq_on ? ctrl_reg.chan_addr :
                       !seq_run_reg ? start_chan :
                       seq_flagged ? step_flagged : step_consec;

    // A control write restarts any sequence from its first channel
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seq_run_reg <= 1'b0;
        end else if (ld_ctrl) begin
            seq_run_reg <= 1'b0;
        end else if (conv_start) begin
            seq_run_reg <= seq_on;
        end
    end

    // ************************************************************
    // Input routing and conversion snapshot
    // ************************************************************
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic neg_gnd;
    asrd_conv_s conv_reg;

    // Configuration combined with channel address; pairing
    always_comb begin
        pos_sel = chan_next;
        neg_sel = CHAN_COMMON_NEG;
        neg_gnd = 1'b0;
        case (ctrl_reg.input_cfg)
            CFG_PSEUDO_7: begin
                neg_sel = CHAN_COMMON_NEG;
            end
            CFG_DIFF_PAIR, CFG_PSEUDO_PAIR: begin
                pos_sel = {chan_next[2:1], 1'b0};
                neg_sel = {chan_next[2:1], 1'b1};
            end
            CFG_SINGLE: begin
                neg_gnd = 1'b1;
            end
            default: begin
                neg_gnd = 1'b1;
            end
        endcase
    end

    // Forbidden address flagged, not routed differently
    assign addr_illegal = (ctrl_reg.input_cfg == CFG_PSEUDO_7) && (chan_next == CHAN_COMMON_NEG);

    // Taken only when a conversion starts
    // Coding and reference from the latest control write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            chan_reg <= ctrl_reg.chan_addr;
            conv_reg <= '0;
        end else if (conv_start) begin
            chan_reg <= chan_next;
            conv_reg.pos_input <= pos_sel;
            conv_reg.neg_input <= neg_sel;
            conv_reg.neg_is_ground <= neg_gnd;
            conv_reg.range_code <= range_of(pos_sel, range_lo_reg, range_hi_reg);
            conv_reg.coding_binary <= ctrl_reg.coding_binary;
            conv_reg.ref_internal <= ctrl_reg.ref_internal;
        end
    end

    assign conv_cfg = conv_reg;

    // ************************************************************
    // Power management
    // ************************************************************
    asrd_pwr_e pwr_state_reg;
    asrd_pwr_e pwr_state_next;

    always_comb begin
        pwr_state_next = pwr_state_reg;
        case (pwr_state_reg)
            PWR_ST_ON: begin
                if (ctrl_reg.power_sel == PWR_FULL_SHDN) pwr_state_next = PWR_ST_OFF;
                else if (conv_done && ctrl_reg.power_sel == PWR_AUTO_STBY) pwr_state_next = PWR_ST_STBY;
                else if (conv_done && ctrl_reg.power_sel == PWR_AUTO_SHDN) pwr_state_next = PWR_ST_OFF;
            end
            PWR_ST_STBY, PWR_ST_OFF: begin
                if (ctrl_reg.power_sel == PWR_FULL_SHDN) pwr_state_next = PWR_ST_OFF;
                else if (conv_start || ctrl_reg.power_sel == PWR_NORMAL) pwr_state_next = PWR_ST_ON;
            end
            default: begin
                pwr_state_next = PWR_ST_ON;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pwr_state_reg <= PWR_ST_ON;
        end else begin
            pwr_state_reg <= pwr_state_next;
        end
    end

    assign pwr_analog_on = (pwr_state_reg == PWR_ST_ON);
    assign pwr_ref_on = ctrl_reg.ref_internal && (pwr_state_reg != PWR_ST_OFF);

    // ************************************************************
    // Data-out idle drive
    // ************************************************************
    logic dout_reg;
    logic dout_oe_reg;

    // Weak drive of next channel msb after the frame
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dout_reg <= 1'b0;
            dout_oe_reg <= 1'b0;
        end else begin
            dout_reg <= chan_next[2];
            dout_oe_reg <= cs_s2_reg & ctrl_reg.dout_weak;
        end
    end

    assign dout_o = dout_reg;
    assign dout_oe = dout_oe_reg;
    assign dout_weak_drv = dout_oe_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ignored_frame_a: assert property (frame_commit && !wr_flag |=> $stable(ctrl_reg) && $stable(range_lo_reg)
        && $stable(range_hi_reg) && $stable(seq_sel_reg)) else $error("read frame changed a register");
    ctrl_load_a: assert property (frame_commit && wr_flag && wr_tgt == TGT_CTRL
        |=> ctrl_reg == asrd_ctrl_s'($past(wr_ctrl))) else $error("control not loaded");
    range_lo_load_a: assert property (ld_rlo |=> range_lo_reg == $past(wr_byte) && $stable(range_hi_reg))
        else $error("low range not loaded");
    range_hi_load_a: assert property (ld_rhi |=> range_hi_reg == $past(wr_byte) && $stable(range_lo_reg))
        else $error("high range not loaded");
    seq_load_a: assert property (ld_seq |=> seq_sel_reg == $past(wr_byte) && $stable(ctrl_reg))
        else $error("sequence not loaded");
    ctrl_hold_a: assert property (!frame_commit |=> $stable(ctrl_reg))
        else $error("control changed without a frame");
    conv_snap_a: assert property (conv_start |=> conv_cfg.coding_binary == $past(ctrl_reg.coding_binary)
        && conv_cfg.ref_internal == $past(ctrl_reg.ref_internal)) else $error("snapshot wrong");
    conv_hold_a: assert property (!conv_start |=> $stable(conv_cfg))
        else $error("conversion settings moved mid conversion");
    consec_end_a: assert property (conv_start && seq_consec && seq_run_reg && chan_reg == ctrl_reg.chan_addr
        |=> chan_reg == 3'h0) else $error("consecutive run did not wrap");
    single_route_a: assert property (conv_start && ctrl_reg.input_cfg == CFG_SINGLE
        |=> conv_cfg.neg_is_ground && conv_cfg.pos_input == $past(chan_next)) else $error("bad routing");
    full_shdn_a: assert property (ctrl_reg.power_sel == PWR_FULL_SHDN |=> !pwr_analog_on)
        else $error("full shutdown not entered");
    weak_drive_a: assert property (cs_s2_reg && ctrl_reg.dout_weak ##1 cs_s2_reg && ctrl_reg.dout_weak
        |-> dout_oe && dout_o == $past(chan_next[2])) else $error("data-out not weakly driven");

    ctrl_write_c: cover property (ld_ctrl);
    ignored_frame_c: cover property (frame_commit && !wr_flag);
    flagged_seq_c: cover property (conv_start && seq_flagged && seq_run_reg);
    auto_stby_c: cover property (pwr_state_reg == PWR_ST_STBY);
endmodule

// ==== asrd_host_model.sv ====
// Host-side serial frame driver for the register decoder bench
`timescale 1ns/1ps
module asrd_host_model (
    output logic sclk_link, // Serial clock, low between frames
    output logic cs_n,      // Chip select, active low
    output logic din        // Serial data to the device
);
    // ************
    // Frame driver
    // ************
    initial begin
        sclk_link = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    task automatic send_frame(input logic [15:0] word, input int edges);
        cs_n = 1'b0;
        for (int i = 15; i > 15 - edges; i--) begin
            // Clocks past the word carry a known filler bit
            din = (i >= 0) ? word[i] : 1'b0;
            #6 sclk_link = 1'b1;
            #6 sclk_link = 1'b0;
        end
        #6 cs_n = 1'b1;
        // Stale bit would hide a late sample
        din = ~din;
    endtask
endmodule

// ==== adc_serial_register_decode_tb.sv ====
// Self-checking bench for the serial register decoder
`timescale 1ns/1ps
module adc_serial_register_decode_tb import asrd_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic conv_start = 1'b0;
    logic conv_done = 1'b0;
    logic sclk_link, cs_n, din, dout_o, dout_oe, dout_weak_drv, addr_illegal, pwr_analog_on, pwr_ref_on;
    asrd_ctrl_s ctrl_q;
    asrd_conv_s conv_cfg;
    logic [7:0] range_lo_q, range_hi_q, seq_sel_q;
    int errors = 0;
    int comparisons = 0;
    logic [11:0] t_ctrl [5] = '{12'ha19, 12'h728, 12'hdd8, 12'h2e0, 12'h000};
    logic [7:0] t_conv [5] = '{8'hb7, 8'h4d, 8'hcf, 8'h04, 8'h14};
    logic [2:0] t_neg [5] = '{3'h0, 3'h3, 3'h7, 3'h1, 3'h0};
    logic [1:0] t_pwr [5] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h2};
    logic [2:0] t_dout [5] = '{3'h7, 3'h0, 3'h1, 3'h0, 3'h0};
    logic [4:0] t_seq [6] = '{5'h03, 5'h0b, 5'h17, 5'h03, 5'h07, 5'h03};

    always #12.5 clk_sys = ~clk_sys;

    asrd_host_model u_host (.sclk_link(sclk_link), .cs_n(cs_n), .din(din));
    asrd_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk_link(sclk_link), .cs_n(cs_n), .din(din),
        .conv_start(conv_start), .conv_done(conv_done), .dout_o(dout_o), .dout_oe(dout_oe),
        .dout_weak_drv(dout_weak_drv), .ctrl_q(ctrl_q), .range_lo_q(range_lo_q), .range_hi_q(range_hi_q),
        .seq_sel_q(seq_sel_q), .conv_cfg(conv_cfg), .addr_illegal(addr_illegal),
        .pwr_analog_on(pwr_analog_on), .pwr_ref_on(pwr_ref_on));

    // *************
    // Shared tasks
    // *************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Eight cycles covers sync, commit and the frame gap
    task automatic wr(input logic [15:0] w, input int n = 16);
        @(negedge clk_sys);
        u_host.send_frame(w, n);
        repeat (8) @(negedge clk_sys);
    endtask

    task automatic pulse(input bit done);
        if (done) conv_done = 1'b1;
        else conv_start = 1'b1;
        @(negedge clk_sys);
        conv_start = 1'b0;
        conv_done = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // *************
    // Test sequence
    // *************
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check("ctrl reset", 16'h0000, {3'h0, dout_oe, ctrl_q});
        check("range reset", 16'h0000, {range_lo_q, range_hi_q});
        wr({1'b1, TGT_RANGE_LO, 8'h6c, 5'h1f});
        wr({1'b1, TGT_RANGE_HI, 8'h9c, 5'h1f});
        wr({1'b1, TGT_SEQ, 8'ha5, 5'h1f});
        check("ranges", 16'h6c9c, {range_lo_q, range_hi_q});
        check("sequence", 16'h00a5, 16'(seq_sel_q));
        for (int t = 0; t < 4; t++) wr({1'b0, 2'(t), 13'h1fff});
        check("no write ctrl", 16'h0000, 16'(ctrl_q));
        check("no write data", 16'h6ca5, {range_lo_q, seq_sel_q});
        wr({1'b1, TGT_CTRL, 12'hfff, 1'b0}, 15);
        check("short frame", 16'h0000, 16'(ctrl_q));
        for (int k = 0; k < 5; k++) begin
            wr({1'b1, TGT_CTRL, t_ctrl[k], 1'(k)});
            check("ctrl", 16'(t_ctrl[k]), 16'(ctrl_q));
            if (k == 0) check("conv held", 16'h0000, 16'(conv_cfg));
            check("drive", 16'(t_dout[k]), 16'({dout_oe, dout_weak_drv, dout_o}));
            pulse(1'b0);
            check("conv", 16'(t_conv[k]), 16'({conv_cfg.pos_input, conv_cfg.neg_is_ground,
                conv_cfg.range_code, conv_cfg.coding_binary, conv_cfg.ref_internal}));
            if (!t_conv[k][4]) check("neg input", 16'(t_neg[k]), 16'(conv_cfg.neg_input));
            pulse(1'b1);
            check("power", 16'(t_pwr[k]), 16'({pwr_analog_on, pwr_ref_on}));
        end
        wr({1'b1, TGT_CTRL, 12'hf86, 1'b0});
        check("illegal addr", 16'h0001, 16'(addr_illegal));
        for (int k = 0; k < 6; k++) begin
            if (k % 3 == 0) wr({1'b1, TGT_CTRL, (k == 0) ? 12'h03a : 12'h23c, 1'b0});
            pulse(1'b0);
            check("seq step", 16'(t_seq[k]), 16'({conv_cfg.pos_input, conv_cfg.coding_binary,
                conv_cfg.ref_internal}));
        end
        wr({1'b1, TGT_SEQ, 8'h3c, 5'h00}, 18);
        check("long frame", 16'h003c, 16'(seq_sel_q));
        print_verdict();
    end

    // Whole run needs about 8.5 us
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
endmodule
